// ---- dv/test_pcr_top.sv ----
// Self-checking bench for the capability registers, both port roles.
`timescale 1ns/1ps
`include "pcr_regs.svh"

module test_pcr_top
  import pcr_pkg::*;
;

  // ****************************************************************
  // Stimulus signals and the two port roles
  // ****************************************************************
  logic         clk_i;
  logic         reset_i;
  pcr_av_req_t  av_req;
  pcr_spl_msg_t spl_msg;
  logic [31:0]  rdata_up;
  logic [31:0]  rdata_dn;
  logic         wait_up;
  logic         wait_dn;
  logic [31:0]  seen_up;
  logic [31:0]  seen_dn;
  int           fails;
  int           n_compared;
  int           s;

  // Both roles share one bus so every access checks them side by side.
  pcr_top #(.IS_UPSTREAM(1'b1), .COMPAT_1P1(1'b0)) pcr_top_inst (
    .clk_i            (clk_i),
    .reset_i          (reset_i),
    .av_req_i         (av_req),
    .spl_msg_i        (spl_msg),
    .av_readdata_o    (rdata_up),
    .av_waitrequest_o (wait_up)
  );

  pcr_top #(.IS_UPSTREAM(1'b0), .COMPAT_1P1(1'b1)) pcr_top_dn_inst (
    .clk_i            (clk_i),
    .reset_i          (reset_i),
    .av_req_i         (av_req),
    .spl_msg_i        (spl_msg),
    .av_readdata_o    (rdata_dn),
    .av_waitrequest_o (wait_dn)
  );

  // Clock of 25 ns period.
  initial clk_i = 1'b0;
  always #12.5 clk_i = ~clk_i;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Counts every comparison; four-state compare so unknowns never match.
  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // The single place where the run ends.
  task automatic complete_run();
    $display("Compared %0d values, %0d mismatches", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One bus cycle. The request holds until the rising edge that samples
  // waitrequest low; data is taken and the request released at that edge.
  task automatic xfer(input logic wr, input logic [7:0] addr,
                      input logic [31:0] wd, input logic [3:0] be);
    int i;
    @(posedge clk_i);
    av_req.read       <= ~wr;
    av_req.write      <= wr;
    av_req.address    <= addr;
    av_req.writedata  <= wd;
    av_req.byteenable <= be;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wait_up === 1'b0) begin
        break;
      end
    end
    if (i == 20) begin
      fails++;
      $display("ERROR waitrequest expected 0 seen %b", wait_up);
      complete_run();
    end
    check("waitrequest_dn", 32'h0, {31'h0, wait_dn});
    seen_up = rdata_up;
    seen_dn = rdata_dn;
    av_req.read  <= 1'b0;
    av_req.write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] e_up,
                        input logic [31:0] e_dn);
    xfer(1'b0, addr, 32'h0, 4'hf);
    check("read_up", e_up, seen_up);
    check("read_dn", e_dn, seen_dn);
  endtask

  // A message pulse; back-to-back calls keep valid high.
  task automatic msg(input logic [7:0] v, input logic [1:0] sc);
    @(posedge clk_i);
    spl_msg <= {1'b1, v, sc};
  endtask

  task automatic msg_end();
    @(posedge clk_i);
    spl_msg.valid <= 1'b0;
  endtask

  task automatic reset_checks();
    rd_chk(`PCR_OFS_CAP_HDR, 32'h4051c010, 32'h0061c010);
    rd_chk(`PCR_OFS_DEV_CAP, 32'h00008024, 32'h00008024);
    rd_chk(`PCR_OFS_WR_LOCK, 32'h0, 32'h0);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  // Slot bit stays clear in every header write, as software must keep it.
  initial begin
    reset_i    = 1'b1;
    av_req     = '0;
    spl_msg    = '0;
    fails      = 0;
    n_compared = 0;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    reset_checks();
    xfer(1'b1, `PCR_OFS_CAP_HDR, 32'hfeffffff, 4'hf);
    xfer(1'b1, `PCR_OFS_DEV_CAP, 32'hffffffff, 4'hf);
    rd_chk(`PCR_OFS_CAP_HDR, 32'h4051c010, 32'h0061c010);
    rd_chk(`PCR_OFS_DEV_CAP, 32'h00008024, 32'h00008024);
    xfer(1'b1, 8'h80, 32'hffffffff, 4'hf);
    rd_chk(8'h80, 32'h0, 32'h0);
    xfer(1'b1, `PCR_OFS_WR_LOCK, 32'hffffffff, 4'hf);
    rd_chk(`PCR_OFS_WR_LOCK, 32'h1, 32'h1);
    xfer(1'b1, `PCR_OFS_CAP_HDR, 32'hfeffffff, 4'hf);
    rd_chk(`PCR_OFS_CAP_HDR, 32'h405fff10, 32'h406fff10);
    xfer(1'b1, `PCR_OFS_DEV_CAP, 32'hffffffff, 4'hf);
    rd_chk(`PCR_OFS_DEV_CAP, 32'h00008027, 32'h00008027);
    xfer(1'b1, `PCR_OFS_CAP_HDR, 32'h00001200, 4'h2);
    rd_chk(`PCR_OFS_CAP_HDR, 32'h405f1210, 32'h406f1210);
    xfer(1'b1, `PCR_OFS_DEV_CAP, 32'h0, 4'h1);
    rd_chk(`PCR_OFS_DEV_CAP, 32'h00008000, 32'h00008000);
    xfer(1'b1, `PCR_OFS_WR_LOCK, 32'h0, 4'hf);
    xfer(1'b1, `PCR_OFS_DEV_CAP, 32'hffffffff, 4'hf);
    rd_chk(`PCR_OFS_DEV_CAP, 32'h00008000, 32'h00008000);
    // Captured power only on the upstream role; the last message wins.
    msg(8'ha5, 2'h2);
    msg_end();
    rd_chk(`PCR_OFS_DEV_CAP, 32'h0a948000, 32'h00008000);
    msg(8'h3c, 2'h3);
    msg(8'h81, 2'h1);
    msg_end();
    rd_chk(`PCR_OFS_DEV_CAP, 32'h06048000, 32'h00008000);
    for (s = 0; s < 4; s++) begin
      msg(8'hff, s[1:0]);
      msg_end();
      rd_chk(`PCR_OFS_DEV_CAP, 32'h03fc8000 | (32'(s) << 26),
             32'h00008000);
    end
    // A second reset in mid-run restores every reset value.
    @(posedge clk_i);
    reset_i <= 1'b1;
    @(posedge clk_i);
    reset_i <= 1'b0;
    reset_checks();
    complete_run();
  end

endmodule

// ---- verilog/pcr_pkg.sv ----
// Types shared by the capability register block.
package pcr_pkg;

  // ****************************************************************
  // Bus request and slot power message carriers
  // ****************************************************************
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } pcr_av_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] value;
    logic [1:0] scale;
  } pcr_spl_msg_t;

endpackage

// ---- verilog/pcr_regs.svh ----
// Offsets, field positions and reset values of the capability registers.
`ifndef PCR_REGS_SVH
`define PCR_REGS_SVH

// ****************************************************************
// Byte offsets on the register bus
// ****************************************************************
`define PCR_OFS_CAP_HDR   8'h40
`define PCR_OFS_DEV_CAP   8'h44
`define PCR_OFS_WR_LOCK   8'hfc

// ****************************************************************
// Capability header field positions
// ****************************************************************
`define PCR_CAPABILITY_IDENTIFIER_LSB     0
`define PCR_NEXT_CAPABILITY_POINTER_LSB    8
`define PCR_VERSION_LSB   16
`define PCR_PTYPE_LSB     20
`define PCR_SLOT_BIT      24
`define PCR_IMSGNUM_LSB   25
`define PCR_TCROUTE_BIT   30

// ****************************************************************
// Device capabilities field positions
// ****************************************************************
`define PCR_MPAY_LSB      0
`define PCR_XTAG_BIT      5
`define PCR_RBER_BIT      15
`define PCR_PLVAL_LSB     18
`define PCR_PLSCALE_LSB   26

// ****************************************************************
// Fixed and reset values
// ****************************************************************
`define PCR_CAPABILITY_IDENTIFIER_VAL     8'h10
`define PCR_NEXT_CAPABILITY_POINTER_RST    8'hc0
`define PCR_VERSION_RST   4'h1
`define PCR_PTYPE_UP      4'h5
`define PCR_PTYPE_DN      4'h6
`define PCR_TCROUTE_RST   1'b1
`define PCR_TCROUTE_COMPAT 1'b0
`define PCR_MPAY_RST      3'h4
`define PCR_XTAG_RST      1'b1
`define PCR_RBER_VAL      1'b1
`define PCR_SLOT_RST      1'b0
`define PCR_UNLOCK_RST    1'b0

`endif

// ---- verilog/pcr_top.sv ----
// Capability header and device capabilities registers for one switch port.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "pcr_regs.svh"


module pcr_top
  import pcr_pkg::*;
#(
  parameter bit IS_UPSTREAM  = 1'b1,
  parameter bit COMPAT_1P1   = 1'b0
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire pcr_av_req_t  av_req_i,
  input  wire pcr_spl_msg_t spl_msg_i,
  output logic [31:0]       av_readdata_o,
  output logic              av_waitrequest_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic        waitreq_reg,  waitreq_next;
  logic [31:0] rdata_reg,    rdata_next;
  logic [7:0]  next_capability_pointer_reg,   next_capability_pointer_next;
  logic [3:0]  version_reg,  version_next;
  logic        slot_reg,     slot_next;
  logic        tcroute_reg,  tcroute_next;
  logic [2:0]  mpay_reg,     mpay_next;
  logic        xtag_reg,     xtag_next;
  logic [7:0]  plval_reg,    plval_next;
  logic [1:0]  plscale_reg,  plscale_next;
  logic        unlock_reg,   unlock_next;

  logic [31:0] cap_img;
  logic [31:0] dcap_img;
  logic [31:0] lock_img;
  logic [31:0] byte_mask;
  logic [31:0] cap_wr;
  logic [31:0] dcap_wr;
  logic        take;
  logic        wr_take;
  logic        hit_cap;
  logic        hit_dcap;
  logic        hit_lock;

  // The traffic class default depends on the compatibility mode, the port type on the port role.
  localparam logic TCROUTE_INIT =
    COMPAT_1P1 ? `PCR_TCROUTE_COMPAT : `PCR_TCROUTE_RST;
  localparam logic [3:0] PTYPE_VAL =
    IS_UPSTREAM ? `PCR_PTYPE_UP : `PCR_PTYPE_DN;

  // ****************************************************************
  // Byte lane mask
  // ****************************************************************
  // Each byte enable opens its eight data bits for a write.
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_lane
      assign byte_mask[gb*8 +: 8] = {8{av_req_i.byteenable[gb]}};
    end
  endgenerate

  // ****************************************************************
  // Address decode and access qualification
  // ****************************************************************
  // A request is served on the single cycle that waitrequest is low.
  assign take     = (av_req_i.read | av_req_i.write) & ~waitreq_reg;
  assign wr_take  = take & av_req_i.write;
  assign hit_cap  = av_req_i.address == `PCR_OFS_CAP_HDR;
  assign hit_dcap = av_req_i.address == `PCR_OFS_DEV_CAP;
  assign hit_lock = av_req_i.address == `PCR_OFS_WR_LOCK;

  // ****************************************************************
  // Read images
  // ****************************************************************
  // Unused bits stay zero, so reserved fields read zero by construction.
  always_comb begin
    cap_img = 32'h0000_0000;
    cap_img[`PCR_CAPABILITY_IDENTIFIER_LSB +: 8]   = `PCR_CAPABILITY_IDENTIFIER_VAL;
    cap_img[`PCR_NEXT_CAPABILITY_POINTER_LSB +: 8]  = next_capability_pointer_reg;
    cap_img[`PCR_VERSION_LSB +: 4] = version_reg;
    cap_img[`PCR_PTYPE_LSB +: 4]   = PTYPE_VAL;
    cap_img[`PCR_SLOT_BIT]         = slot_reg;
    cap_img[`PCR_IMSGNUM_LSB +: 5] = 5'h00;
    cap_img[`PCR_TCROUTE_BIT]      = tcroute_reg;
    dcap_img = 32'h0000_0000;
    dcap_img[`PCR_MPAY_LSB +: 3]   = mpay_reg;
    dcap_img[`PCR_XTAG_BIT]        = xtag_reg;
    dcap_img[`PCR_RBER_BIT]        = `PCR_RBER_VAL;
    dcap_img[`PCR_PLVAL_LSB +: 8]  = plval_reg;
    dcap_img[`PCR_PLSCALE_LSB +: 2] = plscale_reg;
    lock_img = {31'h0000_0000, unlock_reg};
  end
  // Latency and indicator fields are left at zero in dcap_img.

  // Merge the enabled byte lanes of the write data into the current image.
  assign cap_wr  = (cap_img & ~byte_mask) | (av_req_i.writedata & byte_mask);
  assign dcap_wr = (dcap_img & ~byte_mask) |
                   (av_req_i.writedata & byte_mask);

  // ****************************************************************
  // Bus handshake and read data
  // ****************************************************************
  // Waitrequest drops for exactly one cycle per request, which gives a
  // fixed two-cycle access; an unmapped read answers zero.
  always_comb begin
    waitreq_next = 1'b1;
    if (waitreq_reg && (av_req_i.read || av_req_i.write)) begin
      waitreq_next = 1'b0;
    end
    rdata_next = rdata_reg;
    if (waitreq_reg && av_req_i.read) begin
      if (hit_cap) begin
        rdata_next = cap_img;
      end else if (hit_dcap) begin
        rdata_next = dcap_img;
      end else if (hit_lock) begin
        rdata_next = lock_img;
      end else begin
        rdata_next = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      waitreq_reg <= 1'b1;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      waitreq_reg <= waitreq_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign av_waitrequest_o = waitreq_reg;
  assign av_readdata_o    = rdata_reg;

  // ****************************************************************
  // Lockable fields and write lock
  // ****************************************************************
  // Writes to the lockable fields are dropped silently while locked,
  // so software must open the lock before reprogramming defaults.
  always_comb begin
    next_capability_pointer_next  = next_capability_pointer_reg;
    version_next = version_reg;
    slot_next    = slot_reg;
    tcroute_next = tcroute_reg;
    mpay_next    = mpay_reg;
    xtag_next    = xtag_reg;
    unlock_next  = unlock_reg;
    if (wr_take && hit_lock && av_req_i.byteenable[0]) begin
      unlock_next = av_req_i.writedata[0];
    end
    if (wr_take && unlock_reg && hit_cap) begin
      next_capability_pointer_next  = cap_wr[`PCR_NEXT_CAPABILITY_POINTER_LSB +: 8];
      version_next = cap_wr[`PCR_VERSION_LSB +: 4];
      slot_next    = cap_wr[`PCR_SLOT_BIT];
      tcroute_next = cap_wr[`PCR_TCROUTE_BIT];
    end
    if (wr_take && unlock_reg && hit_dcap) begin
      mpay_next = dcap_wr[`PCR_MPAY_LSB +: 3];
      xtag_next = dcap_wr[`PCR_XTAG_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      next_capability_pointer_reg  <= `PCR_NEXT_CAPABILITY_POINTER_RST;
      version_reg <= `PCR_VERSION_RST;
      slot_reg    <= `PCR_SLOT_RST;
      tcroute_reg <= TCROUTE_INIT;
      mpay_reg    <= `PCR_MPAY_RST;
      xtag_reg    <= `PCR_XTAG_RST;
      unlock_reg  <= `PCR_UNLOCK_RST;
    end else begin
      next_capability_pointer_reg  <= next_capability_pointer_next;
      version_reg <= version_next;
      slot_reg    <= slot_next;
      tcroute_reg <= tcroute_next;
      mpay_reg    <= mpay_next;
      xtag_reg    <= xtag_next;
      unlock_reg  <= unlock_next;
    end
  end

  // ****************************************************************
  // Slot power limit capture
  // ****************************************************************
  // Only the upstream port receives the message; downstream the fields
  // are tied so that a stray message cannot leave stale power data.
  always_comb begin
    plval_next   = plval_reg;
    plscale_next = plscale_reg;
    if (!IS_UPSTREAM) begin
      plval_next   = 8'h00;
      plscale_next = 2'h0;
    end else if (spl_msg_i.valid) begin
      plval_next   = spl_msg_i.value;
      plscale_next = spl_msg_i.scale;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      plval_reg   <= 8'h00;
      plscale_reg <= 2'h0;
    end else begin
      plval_reg   <= plval_next;
      plscale_reg <= plscale_next;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_cap_read;
    !av_waitrequest_o && av_req_i.read && hit_cap;
  endsequence

  sequence s_dcap_read;
    !av_waitrequest_o && av_req_i.read && hit_dcap;
  endsequence

  sequence s_locked_cap_write;
    !av_waitrequest_o && av_req_i.write && hit_cap && !unlock_reg;
  endsequence

  sequence s_open_cap_write;
    !av_waitrequest_o && av_req_i.write && hit_cap && unlock_reg &&
    av_req_i.byteenable[1];
  endsequence

  sequence s_open_ver_write;
    !av_waitrequest_o && av_req_i.write && hit_cap && unlock_reg &&
    av_req_i.byteenable[2];
  endsequence

  sequence s_open_dcap_write;
    !av_waitrequest_o && av_req_i.write && hit_dcap && unlock_reg &&
    av_req_i.byteenable[0];
  endsequence

  chk_capability_identifier_fixed: assert property (
    s_cap_read |-> av_readdata_o[7:0] == 8'h10)
    else $error("Capability identifier read back wrong.");

  chk_port_type: assert property (
    s_cap_read |-> av_readdata_o[23:20] == (IS_UPSTREAM ? 4'h5 : 4'h6))
    else $error("Port type read back wrong.");

  chk_imn_zero: assert property (
    s_cap_read |-> av_readdata_o[31:25] == {1'b0, tcroute_reg, 5'h00})
    else $error("Message number or reserved bit not as expected.");

  chk_locked_hold: assert property (
    s_locked_cap_write |=> $stable(next_capability_pointer_reg) && $stable(version_reg) &&
                           $stable(tcroute_reg))
    else $error("Locked write changed a lockable field.");

  chk_open_write: assert property (
    s_open_cap_write |=> next_capability_pointer_reg == $past(av_req_i.writedata[15:8]))
    else $error("Unlocked write did not load the next pointer.");

  chk_open_version: assert property (
    s_open_ver_write |=> version_reg == $past(av_req_i.writedata[19:16]))
    else $error("Unlocked write did not load the version field.");

  chk_open_dcap: assert property (
    s_open_dcap_write |=> mpay_reg == $past(av_req_i.writedata[2:0]) &&
                          xtag_reg == $past(av_req_i.writedata[5]))
    else $error("Unlocked write did not load payload or tag field.");

  chk_dcap_fixed: assert property (
    s_dcap_read |-> av_readdata_o[15:6] == 10'h200 &&
                    av_readdata_o[4:3] == 2'h0)
    else $error("Fixed device capability bits read back wrong.");

  chk_dcap_rsvd: assert property (
    s_dcap_read |-> av_readdata_o[17:16] == 2'h0 &&
                    av_readdata_o[31:28] == 4'h0)
    else $error("Reserved device capability bits not zero.");

  chk_spl_capture: assert property (
    spl_msg_i.valid |=> plval_reg ==
      (IS_UPSTREAM ? $past(spl_msg_i.value) : 8'h00) &&
      plscale_reg == (IS_UPSTREAM ? $past(spl_msg_i.scale) : 2'h0))
    else $error("Slot power limit capture wrong.");

  chk_ack_pulse: assert property (
    (av_req_i.read || av_req_i.write) && av_waitrequest_o
      |=> !av_waitrequest_o ##1 av_waitrequest_o)
    else $error("Waitrequest did not drop for exactly one cycle.");

endmodule
